// >>> common/strap_pkg.sv
// constants for the control-mode strap and clock power block
// assumes one system clock; register bus is the device's own write/read port
package strap_pkg;
  localparam logic [6:0] SRC_REG_ADDR = 7'h15;
  localparam logic [6:0] PD_REG_ADDR = 7'h1E;
  localparam int SRC_SEL_BIT = 6;
  localparam int SYNTH_PD_BIT = 0;
  localparam int TX_PD_BIT = 2;
  localparam int OSC_PD_BIT = 3;
  localparam logic [7:0] SRC_REG_RESET = 8'h40;
  localparam logic [7:0] PD_REG_RESET = 8'h0D;
  localparam int REF_CLOCK_KHZ = 12000;
  typedef enum logic [1:0] {FMT_I2S16, FMT_I2S24, FMT_LJ24_FLAGS, FMT_RJ16} aif_format_t;
endpackage

// >>> common/strap_if.sv
// strap capture carrier between top and capture module
// assumes one clock domain
`timescale 1ns/1ps
interface strap_if;
  logic valid;
  logic sw_mode;
  logic master;
  logic tx_source;
  logic [1:0] fmt;
  modport cap (output valid, output sw_mode, output master, output tx_source, output fmt);
  modport top (input valid, input sw_mode, input master, input tx_source, input fmt);
endinterface

// >>> rtl/strap_capture.sv
// samples strap pins once, on the first clock after reset release
// assumes pins are settled and synchronous by then
`timescale 1ns/1ps
module strap_capture
  import strap_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // strap pins
  input wire logic data_pin_i,
  input wire logic clock_pin_i,
  input wire logic select_pin_i,
  input wire logic readback_pin_i,
  input wire logic gen_out_pin_i,
  // captured values
  strap_if.cap st
);
  logic valid_r, valid_nxt;
  logic [4:0] val_r, val_nxt;

  // latch once; held until next reset even while pins turn to outputs
  always_comb
  begin
    valid_nxt = 1'b1;
    val_nxt = valid_r ? val_r
      : {data_pin_i, clock_pin_i, select_pin_i, gen_out_pin_i, readback_pin_i}; // [RL18]
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      valid_r <= 1'b0;
      val_r <= 5'h00;
    end
    else
    begin
      valid_r <= valid_nxt;
      val_r <= val_nxt;
    end
  end

  assign st.valid = valid_r;
  assign st.sw_mode = val_r[4]; // [RL1]
  assign st.master = val_r[3];
  assign st.tx_source = val_r[2];
  assign st.fmt = val_r[1:0];
endmodule

// >>> rtl/strap_clock_ctrl.sv
// control-mode strap and clock power control
// assumes straps are settled at reset release and the register port is synchronous
// Summary of operation
// RL1 - control data pin at reset: low is hardware mode, high software mode
// RL2 - hardware mode powers every block up, unstrapped features take defaults
// RL3 - hardware mode keeps recovery defaults, assuming a 12 MHz reference
// RL4 - master role from register bit in software, clock strap in hardware
// RL5 - hardware mode transmit source from the select strap pin
// RL6 - hardware mode shared audio format from the two-bit strap
// RL7 - software mode sets receive and transmit formats separately
// RL8 - hardware mode drives status flags on the strap pins
// RL9 - transmitter power-down is bit 2 of 1Eh, resets to 1
// RL10 - transmit source is bit 6 of 15h, resets to 1
// RL11 - software powers transmitter down around source changes
// RL12 - software keeps oscillator on while synthesiser or receiver enabled
// RL13 - oscillator clock selectable for master clock and clock output pins
// RL14 - oscillator power-down is bit 3 of 1Eh, resets to 1
// RL15 - synthesiser power-down is bit 0 of 1Eh, resets to 1
// RL16 - synthesiser builds receive, pin and transmit encode clocks from oscillator; of these, code gates only the receive clock on osc_pd
// RL17 - receiver enabled gives automatic synthesiser mode, else manual; code also forces automatic mode in hardware mode
// RL18 - strap values are latched and held until the next reset
`timescale 1ns/1ps
module strap_clock_ctrl
  import strap_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // register port
  input wire logic reg_wr_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // software-mode settings from other registers
  input wire logic sw_master_i,
  input wire logic [3:0] sw_rx_fmt_i,
  input wire logic [3:0] sw_tx_fmt_i,
  input wire logic rx_enable_i,
  input wire logic mclk_pin_from_osc_i,
  input wire logic clock_output_pin_from_osc_i,
  // raw clocks
  input wire logic osc_raw_i,
  input wire logic synth_clk_i,
  input wire logic synth_clk_b_i,
  input wire logic mclk_in_i,
  // status flags
  input wire logic transmission_error_flag_i,
  input wire logic non_audio_flag_i,
  input wire logic unlock_flag_i,
  input wire logic general_status_flag_i,
  // strap pins, two-way
  input wire logic control_data_pin_i,
  input wire logic control_clock_pin_i,
  output logic control_clock_pin_o,
  output logic control_clock_pin_oe_o,
  input wire logic control_select_pin_i,
  output logic control_select_pin_o,
  output logic control_select_pin_oe_o,
  input wire logic control_readback_pin_i,
  output logic control_readback_pin_o,
  output logic control_readback_pin_oe_o,
  input wire logic general_output_0_i,
  output logic general_output_0_o,
  output logic general_output_0_oe_o,
  // resolved configuration
  output logic sw_mode_o,
  output logic interface_master_select_o,
  output logic transmit_source_select_o,
  output logic [3:0] rx_fmt_o,
  output logic [3:0] tx_fmt_o,
  output logic recovery_defaults_o,
  output logic oscillator_power_down_o,
  output logic synth_power_down_o,
  output logic transmitter_power_down_o,
  output logic synth_auto_mode_o,
  // clocks out
  output logic oscillator_clock_o,
  output logic mclk_pin_clk_o,
  output logic clock_output_pin_o,
  output logic transmit_encode_clock_o,
  output logic rx_recovery_clock_o
);
  // captured strap values from the capture module
  strap_if st();
  // register file state
  logic [7:0] src_reg_r, src_reg_nxt;
  logic [7:0] pd_reg_r, pd_reg_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  // decoded register port strobes
  logic wr_src, wr_pd;
  // resolved mode and forced power-downs
  logic hw;
  logic osc_pd, syn_pd, tx_pd;
  logic [3:0] hw_fmt;
  // transmitter encode source before the power gate
  logic enc_src;

  // strap capture kept apart so pin reuse cannot disturb the latch
  strap_capture u_cap (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .data_pin_i(control_data_pin_i),
    .clock_pin_i(control_clock_pin_i),
    .select_pin_i(control_select_pin_i),
    .readback_pin_i(control_readback_pin_i),
    .gen_out_pin_i(general_output_0_i),
    .st(st)
  );

  // hardware mode only after the straps are caught
  // before capture the block behaves as software mode with pins released
  assign hw = st.valid & ~st.sw_mode; // [RL1]

  // write decode; writes ignored in hardware mode so straps always win
  assign wr_src = reg_wr_i & ~hw & (reg_addr_i == SRC_REG_ADDR);
  assign wr_pd = reg_wr_i & ~hw & (reg_addr_i == PD_REG_ADDR);

  // next register values, full byte stored on a write
  always_comb
  begin
    src_reg_nxt = src_reg_r;
    pd_reg_nxt = pd_reg_r;
    if (wr_src)
    begin
      src_reg_nxt = reg_wdata_i; // [RL10]
    end
    if (wr_pd)
    begin
      pd_reg_nxt = reg_wdata_i; // [RL9] [RL14] [RL15]
    end
  end

  // read mux; unknown addresses read as zero, no error reported
  always_comb
  begin
    rdata_nxt = 8'h00;
    case (reg_addr_i)
      SRC_REG_ADDR:
      begin
        rdata_nxt = src_reg_r;
      end
      PD_REG_ADDR:
      begin
        rdata_nxt = pd_reg_r;
      end
      default:
      begin
        rdata_nxt = 8'h00;
      end
    endcase
  end

  // register stage; read data lags the address by one cycle
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      src_reg_r <= SRC_REG_RESET; // [RL10]
      pd_reg_r <= PD_REG_RESET; // [RL9] [RL14] [RL15]
      rdata_r <= 8'h00;
    end
    else
    begin
      src_reg_r <= src_reg_nxt;
      pd_reg_r <= pd_reg_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // registered read data straight to the port
  assign reg_rdata_o = rdata_r;

  // hardware mode forces every block powered up
  // register bits keep their value, so a readback in hardware mode may differ
  assign osc_pd = hw ? 1'b0 : pd_reg_r[OSC_PD_BIT]; // [RL2] [RL14]
  assign syn_pd = hw ? 1'b0 : pd_reg_r[SYNTH_PD_BIT]; // [RL2] [RL15]
  assign tx_pd = hw ? 1'b0 : pd_reg_r[TX_PD_BIT]; // [RL2] [RL9]
  assign oscillator_power_down_o = osc_pd;
  assign synth_power_down_o = syn_pd;
  assign transmitter_power_down_o = tx_pd;

  // role, source and format selection by mode
  assign sw_mode_o = ~hw;
  assign interface_master_select_o = hw ? st.master : sw_master_i; // [RL4]
  assign transmit_source_select_o = hw ? st.tx_source : src_reg_r[SRC_SEL_BIT]; // [RL5] [RL10]
  // hardware format shares one code for both sides
  assign hw_fmt = {2'b00, st.fmt}; // [RL6]
  assign rx_fmt_o = hw ? hw_fmt : sw_rx_fmt_i; // [RL6] [RL7]
  assign tx_fmt_o = hw ? hw_fmt : sw_tx_fmt_i; // [RL7]
  // recovery defaults cannot be altered while strapped
  assign recovery_defaults_o = hw; // [RL3]
  // receiver enabled drives synthesiser automatically; hardware mode has it on
  assign synth_auto_mode_o = hw | rx_enable_i; // [RL17]

  // status flags replace strap inputs only after capture, to avoid a drive fight
  assign control_clock_pin_o = transmission_error_flag_i; // [RL8]
  assign control_readback_pin_o = non_audio_flag_i; // [RL8]
  assign control_select_pin_o = unlock_flag_i; // [RL8]
  assign general_output_0_o = general_status_flag_i; // [RL8]
  assign control_clock_pin_oe_o = hw;
  assign control_readback_pin_oe_o = hw;
  assign control_select_pin_oe_o = hw;
  assign general_output_0_oe_o = hw;

  // clock gating: plain and-gates, a model of the analogue enables
  assign oscillator_clock_o = osc_raw_i & ~osc_pd; // [RL14]
  assign mclk_pin_clk_o = mclk_pin_from_osc_i ? oscillator_clock_o : synth_clk_i; // [RL13]
  assign clock_output_pin_o = clock_output_pin_from_osc_i ? oscillator_clock_o : synth_clk_i; // [RL13]
  // receive recovery clock only exists while the synthesiser runs from a live oscillator
  assign rx_recovery_clock_o = synth_clk_i & ~syn_pd & ~osc_pd; // [RL16]
  // route change while running may glitch; software powers down first
  assign enc_src = transmit_source_select_o ? mclk_in_i : (synth_clk_b_i & ~syn_pd); // [RL10]
  // powered-down transmitter sees no encode clock at all
  assign transmit_encode_clock_o = tx_pd ? 1'b0 : enc_src; // [RL9] [RL16]
endmodule

// >>> test/strap_clock_checker.sv
// port checks for the strap and clock power block
// assumes bind into strap_clock_ctrl, one clock domain
`timescale 1ns/1ps
module strap_clock_checker
  import strap_pkg::*;
(
  input wire logic mclk_i, rst_i, reg_wr_i, sw_mode_o, rx_enable_i, recovery_defaults_o,
  input wire logic [6:0] reg_addr_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [3:0] rx_fmt_o, tx_fmt_o,
  input wire logic transmission_error_flag_i, non_audio_flag_i, unlock_flag_i,
  input wire logic general_status_flag_i, control_clock_pin_o, control_clock_pin_oe_o,
  input wire logic control_select_pin_o, control_readback_pin_o, general_output_0_o,
  input wire logic oscillator_power_down_o, synth_power_down_o, transmitter_power_down_o,
  input wire logic transmit_source_select_o, synth_auto_mode_o, oscillator_clock_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // quiet read, straps caught; the release edge still shows reset defaults
  sequence rd_at(logic [6:0] a);
    !$past(rst_i) && sw_mode_o && !reg_wr_i && reg_addr_i == a;
  endsequence
  a_hw_power: assert property (!sw_mode_o |->
    !(oscillator_power_down_o | synth_power_down_o | transmitter_power_down_o))
    else $error("powered down in hw mode");
  a_flag_pins: assert property (!sw_mode_o |-> control_clock_pin_oe_o &&
    control_clock_pin_o == transmission_error_flag_i && control_select_pin_o == unlock_flag_i
    && control_readback_pin_o == non_audio_flag_i && general_output_0_o == general_status_flag_i)
    else $error("flag pin wrong");
  a_strap_hold: assert property ($past(!rst_i, 2) |-> $stable(sw_mode_o))
    else $error("mode changed");
  a_pd_read: assert property (rd_at(PD_REG_ADDR) |=>
    reg_rdata_o[3:2] == {oscillator_power_down_o, transmitter_power_down_o}
    && reg_rdata_o[0] == synth_power_down_o) else $error("power bits differ");
  a_src_read: assert property (rd_at(SRC_REG_ADDR) |=>
    reg_rdata_o[6] == transmit_source_select_o) else $error("source bit differs");
  a_osc_gate: assert property (oscillator_power_down_o |-> !oscillator_clock_o)
    else $error("osc clock while down");
  a_auto_mode: assert property (synth_auto_mode_o == (!sw_mode_o || rx_enable_i))
    else $error("synth mode wrong");
  a_hw_format: assert property (!sw_mode_o |-> rx_fmt_o == tx_fmt_o && rx_fmt_o[3:2] == 0
    && recovery_defaults_o) else $error("hw format wrong");
endmodule
bind strap_clock_ctrl strap_clock_checker i_chk (.*);

// >>> test/strap_board.sv
// strap resistors and the resolved two-way strap pin wires
// assumes the device drives a pin only while its enable is high
`timescale 1ns/1ps
module strap_board (
  input wire logic [4:0] strap_i,
  input wire logic control_clock_pin_o, control_clock_pin_oe_o, control_select_pin_o,
  input wire logic control_select_pin_oe_o, control_readback_pin_o, control_readback_pin_oe_o,
  input wire logic general_output_0_o, general_output_0_oe_o,
  output logic control_data_pin_i, control_clock_pin_i, control_select_pin_i,
  output logic control_readback_pin_i, general_output_0_i
);
  // resistor level unless driven; resistors stay, so the pin shows them when released
  assign control_data_pin_i = strap_i[0];
  assign control_clock_pin_i = control_clock_pin_oe_o ? control_clock_pin_o : strap_i[1];
  assign control_select_pin_i = control_select_pin_oe_o ? control_select_pin_o : strap_i[2];
  assign control_readback_pin_i = control_readback_pin_oe_o ? control_readback_pin_o : strap_i[3];
  assign general_output_0_i = general_output_0_oe_o ? general_output_0_o : strap_i[4];
endmodule

// >>> test/strap_clock_ctrl_tb.sv
// bench for strap_clock_ctrl: both control modes and the power registers
// assumes strap_board and the checker bind are compiled before it
`timescale 1ns/1ps
module strap_clock_ctrl_tb;
  logic mclk_i = 0, rst_i = 1, reg_wr_i = 0, osc_raw_i = 0, sw_master_i = 1, rx_enable_i = 0;
  logic mclk_pin_from_osc_i = 1, clock_output_pin_from_osc_i = 1, synth_clk_i, synth_clk_b_i, mclk_in_i;
  logic [6:0] reg_addr_i = 0;
  logic [7:0] reg_wdata_i = 0, reg_rdata_o;
  logic [3:0] sw_rx_fmt_i = 4'h5, sw_tx_fmt_i = 4'hA, rx_fmt_o, tx_fmt_o, fl = 0;
  logic [4:0] strap_i = 5'h01;
  logic transmission_error_flag_i, non_audio_flag_i, unlock_flag_i, general_status_flag_i;
  logic control_data_pin_i, control_clock_pin_i, control_clock_pin_o, control_clock_pin_oe_o;
  logic control_select_pin_i, control_select_pin_o, control_select_pin_oe_o, general_output_0_i;
  logic control_readback_pin_i, control_readback_pin_o, control_readback_pin_oe_o;
  logic general_output_0_o, general_output_0_oe_o, sw_mode_o, interface_master_select_o;
  logic transmit_source_select_o, recovery_defaults_o, oscillator_power_down_o, synth_auto_mode_o;
  logic synth_power_down_o, transmitter_power_down_o, oscillator_clock_o, mclk_pin_clk_o;
  logic clock_output_pin_o, transmit_encode_clock_o, rx_recovery_clock_o;
  int fails = 0, n_compared = 0;
  initial forever #5 mclk_i = ~mclk_i;
  // half-rate raw clocks and ever-changing flags
  always @(posedge mclk_i)
  begin
    #1 osc_raw_i = ~osc_raw_i;
    fl = fl + 4'h1;
  end
  assign {synth_clk_i, synth_clk_b_i, mclk_in_i} = {3{osc_raw_i}};
  assign {transmission_error_flag_i, non_audio_flag_i, unlock_flag_i, general_status_flag_i} = fl;
  strap_clock_ctrl i_dut (.*);
  strap_board i_brd (.*);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one register cycle; read data is settled one edge after the address
  task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d);
    @(posedge mclk_i) #1;
    {reg_wr_i, reg_addr_i, reg_wdata_i} = {w, a, d};
    @(posedge mclk_i) #1;
    reg_wr_i = 0;
  endtask
  // reset with straps held through the capture edge
  task automatic boot(input logic [4:0] s);
    rst_i = 1;
    strap_i = s;
    repeat (20) @(posedge mclk_i);
    #1 rst_i = 0;
    repeat (2) @(posedge mclk_i);
  endtask
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    boot(5'h01);
    chk(sw_mode_o, 1);
    chk({oscillator_clock_o, rx_recovery_clock_o, transmit_encode_clock_o}, 0);
    xfer(0, 7'h15, 0);
    chk(reg_rdata_o, 8'h40);
    xfer(0, 7'h1E, 0);
    chk(reg_rdata_o, 8'h0D);
    xfer(0, 7'h7F, 0);
    chk(reg_rdata_o, 8'h00);
    // transmitter stays down while the route moves; osc up with the synth
    xfer(1, 7'h1E, 8'h04);
    xfer(1, 7'h15, 8'h00);
    xfer(1, 7'h1E, 8'h00);
    chk({oscillator_power_down_o, synth_power_down_o, transmitter_power_down_o,
      transmit_source_select_o, interface_master_select_o}, 8'h01);
    chk({rx_fmt_o, tx_fmt_o}, 8'h5A);
    // every gated clock follows the raw clock once all is powered up
    #2 chk({oscillator_clock_o, mclk_pin_clk_o, clock_output_pin_o, transmit_encode_clock_o,
      rx_recovery_clock_o}, {5{osc_raw_i}});
    #10 chk({oscillator_clock_o, mclk_pin_clk_o, clock_output_pin_o, transmit_encode_clock_o,
      rx_recovery_clock_o}, {5{osc_raw_i}});
    $display("test sw done");
    // each hw format code, select strap following the low format bit
    for (int k = 0; k < 4; k++)
    begin
      boot({k[1:0], k[0], 2'b10});
      xfer(1, 7'h1E, 8'h0F);
      chk({sw_mode_o, interface_master_select_o, transmit_source_select_o, rx_fmt_o},
        8'h20 | (k[0] << 4) | k);
      chk({oscillator_power_down_o, transmitter_power_down_o, recovery_defaults_o}, 1);
    end
    $display("test hw done");
    end_sim;
  end
  initial
  begin
    #20000 fails++;
    end_sim;
  end
endmodule
